/* design/tmrl_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef TMRL_DEFINES_SVH
`define TMRL_DEFINES_SVH

// Register offsets on the 3-bit register port
`define TMRL_OFS_PERIOD 3'h0
`define TMRL_OFS_COUNT 3'h1
`define TMRL_OFS_CTRL 3'h2
`define TMRL_OFS_RST_SEL 3'h3
`define TMRL_OFS_DUTY 3'h4
`define TMRL_OFS_STATUS 3'h5

// Control register fields
`define TMRL_CTRL_ON_BIT 7
`define TMRL_CTRL_INSTR_BIT 5
`define TMRL_CTRL_MODE_MSB 4
`define TMRL_CTRL_MODE_LSB 0

// Reset source select field and writable mask
`define TMRL_RESET_SOURCE_SELECT_MSB 4
`define TMRL_RESET_SOURCE_SELECT_LSB 0
`define TMRL_RESET_SOURCE_SELECT_MASK 8'h1F

// Status register fields
`define TMRL_STAT_ERS_BIT 0
`define TMRL_STAT_ON_BIT 1
`define TMRL_STAT_PWM_BIT 2

// Reset values
`define TMRL_PERIOD_RST 8'hFF
`define TMRL_CTRL_RST 8'h00
`define TMRL_RESET_SOURCE_SELECT_RST 8'h00
`define TMRL_DUTY_RST 8'h00

// Timer clocks the PWM stays off after an early external reset
`define TMRL_PWM_RESTART_CYC 2'h2

`endif

/* design/tmrl_pkg.sv */
// Types shared by the timer external reset limit design
package tmrl_pkg;

  // Operating mode codes of the 5-bit mode field
  typedef enum logic [4:0] {
    TMRL_MODE_FREE = 5'h00,
    TMRL_MODE_EDGE_BOTH = 5'h03,
    TMRL_MODE_EDGE_RISE = 5'h04,
    TMRL_MODE_EDGE_FALL = 5'h05
  } tmrl_mode_type;

  // Reset source selector codes, not all listed; 01100, 01101 and 11001 up are reserved
  typedef enum logic [4:0] {
    TMRL_SRC_PIN = 5'h00,
    TMRL_SRC_TMR1 = 5'h01,
    TMRL_SRC_TMR3 = 5'h03,
    TMRL_SRC_CCP1 = 5'h04,
    TMRL_SRC_PWM5 = 5'h08,
    TMRL_SRC_PWM8 = 5'h0B,
    TMRL_SRC_CMP1 = 5'h0E,
    TMRL_SRC_ZCD = 5'h10,
    TMRL_SRC_CELL1 = 5'h11,
    TMRL_SRC_UART1_RX = 5'h15,
    TMRL_SRC_UART2_TX = 5'h18
  } tmrl_src_type;

endpackage

/* design/tmrl_sync.sv */
// Resynchroniser with selectable depth and edge detection
`timescale 1ns/1ns
module tmrl_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Raw level and depth select
  input wire logic din_i,
  input wire logic fast_i,
  // Synchronised level and edge pulses
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_reg;
  logic hold_reg;
  logic fast_reg;
  logic prev_reg;

  // Two-stage path; the first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      meta_reg <= din_i;
      hold_reg <= meta_reg;
    end
  end

  // Single-stage path for the instruction clock case
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= din_i;
    end
  end

  assign level_o = fast_i ? fast_reg : hold_reg;

  // Previous sample, so one edge gives one single-cycle pulse
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_reg;
  assign fall_o = ~level_o & prev_reg;

endmodule

/* design/tmrl_timer.sv */
// 8-bit period timer with selectable external reset and edge limit modes
`timescale 1ns/1ns
`include "tmrl_defines.svh"
module tmrl_timer #(
  parameter int TIMER_INDEX = 1,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Reset source candidates
  input wire logic timer_input_pin_route_i,
  input wire logic [2:0] timer_postscaled_i,
  input wire logic [3:0] capture_compare_output_i,
  input wire logic [3:0] pwm_generator_output_i,
  input wire logic [1:0] comparator_output_i,
  input wire logic zero_cross_output_i,
  input wire logic [3:0] logic_cell_output_i,
  input wire logic [3:0] uart_edge_i,
  // Timer outputs
  output logic [DATA_W-1:0] count_o,
  output logic period_match_o,
  output logic ext_clear_o,
  output logic pwm_o
);

  // This timer's own postscaled output is never its own reset source
  // TIMER_INDEX runs 1 to 3; values above 3 mask nothing
  localparam logic [2:0] OWN_POST_MASK = 3'(1 << (TIMER_INDEX - 1));

  // Registers written by software
  logic [DATA_W-1:0] period_reg;
  logic [DATA_W-1:0] duty_reg;
  logic [DATA_W-1:0] ctrl_reg;
  logic [4:0] reset_source_select_reg;

  // Timer state
  logic [DATA_W-1:0] count_reg;
  logic [DATA_W-1:0] count_next;
  logic match_reg;
  logic clear_reg;
  logic pwm_reg;
  logic [1:0] restart_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Derived control
  logic on_ctrl;
  logic instr_clk;
  tmrl_pkg::tmrl_mode_type mode;
  logic [31:0] source_vec;
  logic external_reset_input;
  logic ers_level;
  logic ers_rise;
  logic ers_fall;
  logic on_sync;
  logic ext_hit;
  logic at_period;
  logic pwm_level;
  logic [DATA_W-1:0] status_word;

  // Decide whether an edge qualifies in the given mode
  // Any other mode code runs free on the period compare alone
  function automatic logic edge_qualifies(
    input tmrl_pkg::tmrl_mode_type m,
    input logic rise,
    input logic fall
  );
    logic hit;
    hit = 1'b0;
    case (m)
      tmrl_pkg::TMRL_MODE_EDGE_BOTH: hit = rise | fall;
      tmrl_pkg::TMRL_MODE_EDGE_RISE: hit = rise;
      tmrl_pkg::TMRL_MODE_EDGE_FALL: hit = fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Zero the bits of a write that fall outside the mask of implemented bits
  function automatic logic [DATA_W-1:0] masked_write(
    input logic [DATA_W-1:0] wdata,
    input logic [DATA_W-1:0] mask
  );
    return wdata & mask;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_sel(
    input logic wr,
    input logic [2:0] addr,
    input logic [2:0] ofs
  );
    return wr && (addr == ofs);
  endfunction

  assign on_ctrl = ctrl_reg[`TMRL_CTRL_ON_BIT];
  assign instr_clk = ctrl_reg[`TMRL_CTRL_INSTR_BIT];
  assign mode = tmrl_pkg::tmrl_mode_type'(
    ctrl_reg[`TMRL_CTRL_MODE_MSB:`TMRL_CTRL_MODE_LSB]);

  // Selector table; reserved codes sit as constant zero
  assign source_vec = {
    7'h00, // 11111..11001 reserved
    uart_edge_i, // 11000..10101
    logic_cell_output_i, // 10100..10001
    zero_cross_output_i, // 10000
    comparator_output_i, // 01111..01110
    2'h0, // 01101..01100 reserved
    pwm_generator_output_i, // 01011..01000
    capture_compare_output_i, // 00111..00100
    timer_postscaled_i & ~OWN_POST_MASK,
    timer_input_pin_route_i
  };

  // Index by the 5-bit selector
  assign external_reset_input = source_vec[reset_source_select_reg];

  // Resync of the external reset input; depth follows the clock choice
  // Flipping the clock choice while the input moves can show one false
  // edge, so set the clock choice before the timer is switched on
  tmrl_sync u_ers_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .din_i(external_reset_input),
    .fast_i(instr_clk),
    .level_o(ers_level),
    .rise_o(ers_rise),
    .fall_o(ers_fall)
  );

  // Resync of the on control, same depth rule as the reset input
  tmrl_sync u_on_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .din_i(on_ctrl),
    .fast_i(instr_clk),
    .level_o(on_sync),
    .rise_o(),
    .fall_o()
  );

  // Only a running timer honours an external reset edge
  assign ext_hit = on_sync & edge_qualifies(mode, ers_rise, ers_fall);
  assign at_period = (count_reg == period_reg);

  // Level the PWM takes when no hold-off applies
  assign pwm_level = (count_next < duty_reg);

  // Next count; an external hit beats the period compare
  always_comb begin
    count_next = count_reg;
    if (on_sync) begin
      if (ext_hit) begin
        count_next = '0;
      end else if (at_period) begin
        count_next = '0;
      end else begin
        count_next = DATA_W'(count_reg + 1'b1);
      end
    end
  end

  // Period register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      period_reg <= `TMRL_PERIOD_RST;
    end else if (wr_sel(reg_wr_i, reg_addr_i, `TMRL_OFS_PERIOD)) begin
      period_reg <= reg_wdata_i;
    end
  end

  // Duty register for the attached PWM
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      duty_reg <= `TMRL_DUTY_RST;
    end else if (wr_sel(reg_wr_i, reg_addr_i, `TMRL_OFS_DUTY)) begin
      duty_reg <= reg_wdata_i;
    end
  end

  // Control register: on, clock choice, mode; bit 6 unused
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_reg <= `TMRL_CTRL_RST;
    end else if (wr_sel(reg_wr_i, reg_addr_i, `TMRL_OFS_CTRL)) begin
      ctrl_reg <= masked_write(reg_wdata_i, 8'hBF);
    end
  end

  // Reset source select keeps only its five implemented bits
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reset_source_select_reg <= 5'(`TMRL_RESET_SOURCE_SELECT_RST);
    end else if (wr_sel(reg_wr_i, reg_addr_i, `TMRL_OFS_RST_SEL)) begin
      reset_source_select_reg <=
        5'(masked_write(reg_wdata_i, `TMRL_RESET_SOURCE_SELECT_MASK));
    end
  end

  // Counter; a software write loads it, otherwise it runs
  // A write landing on the edge of a reset event keeps the written value
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      count_reg <= '0;
    end else if (wr_sel(reg_wr_i, reg_addr_i, `TMRL_OFS_COUNT)) begin
      count_reg <= reg_wdata_i;
    end else begin
      count_reg <= count_next;
    end
  end

  // Period match and external clear pulses, one cycle each
  // Both still pulse when a count write lands in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      match_reg <= 1'b0;
      clear_reg <= 1'b0;
    end else begin
      match_reg <= on_sync & at_period & ~ext_hit;
      clear_reg <= ext_hit;
    end
  end

  // Hold-off after an early reset; counts timer clocks down to zero
  // The counter keeps running meanwhile; only the PWM level is held
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      restart_reg <= 2'h0;
    end else if (ext_hit) begin
      restart_reg <= `TMRL_PWM_RESTART_CYC;
    end else if (restart_reg != 2'h0) begin
      restart_reg <= restart_reg - 2'h1;
    end
  end

  // PWM output: high while count is below duty, forced low during
  // hold-off so the shortened period never leaves a runt pulse
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pwm_reg <= 1'b0;
    end else if (!on_sync || ext_hit) begin
      pwm_reg <= 1'b0;
    end else if (restart_reg > 2'h1) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_level;
    end
  end

  // Status word; unused bits read as zero
  always_comb begin
    status_word = '0;
    status_word[`TMRL_STAT_ERS_BIT] = ers_level;
    status_word[`TMRL_STAT_ON_BIT] = on_sync;
    status_word[`TMRL_STAT_PWM_BIT] = pwm_reg;
  end

  // Read data valid in the cycle after the read strobe only
  // Unmapped offsets and idle cycles return zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TMRL_OFS_PERIOD: rdata_reg <= period_reg;
        `TMRL_OFS_COUNT: rdata_reg <= count_reg;
        `TMRL_OFS_CTRL: rdata_reg <= ctrl_reg;
        `TMRL_OFS_RST_SEL: rdata_reg <= {3'h0, reset_source_select_reg};
        `TMRL_OFS_DUTY: rdata_reg <= duty_reg;
        `TMRL_OFS_STATUS: rdata_reg <= status_word;
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // Outputs, all from flip-flops
  assign reg_rdata_o = rdata_reg;
  assign count_o = count_reg;
  assign period_match_o = match_reg;
  assign ext_clear_o = clear_reg;
  assign pwm_o = pwm_reg;

endmodule

/* tb/tmrl_src_model.sv */
// Model of the on-chip signals that feed the reset source selector
`timescale 1ns/1ns
module tmrl_src_model (
  // Clock
  input wire logic sys_clk_i,
  // Line to drive and its level
  input wire logic [4:0] sel_i,
  input wire logic level_i,
  // All candidate lines, index equals selector code
  output logic [24:0] src_o
);
  logic tgl_reg = 1'b0;

  // Unselected lines toggle, so a wrong route shows up as edges
  always_ff @(posedge sys_clk_i) begin
    tgl_reg <= ~tgl_reg;
  end

  // The selected line follows the requested level
  always_comb begin
    for (int k = 0; k < 25; k++) begin
      src_o[k] = (k == sel_i) ? level_i : tgl_reg;
    end
  end
endmodule

/* tb/tmrl_timer_checker.sv */
// Port assertions for the timer external reset limit block
`timescale 1ns/1ns
module tmrl_timer_checker #(
  parameter int TIMER_INDEX = 1,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Timer outputs
  input wire logic [DATA_W-1:0] count_o,
  input wire logic period_match_o,
  input wire logic ext_clear_o,
  input wire logic pwm_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // Register read path
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  reset_source_select_hi_a: assert property ($past(reg_rd_i) &&
    $past(reg_addr_i) == 3'h3 |-> reg_rdata_o[7:5] == 3'h0)
    else $error("selector upper bits not zero");
  unmapped_a: assert property ($past(reg_rd_i) &&
    $past(reg_addr_i) > 3'h5 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  count_rd_a: assert property ($past(reg_rd_i) &&
    $past(reg_addr_i) == 3'h1 |-> reg_rdata_o == $past(count_o))
    else $error("count read differs from count");

  // Clear pulses; pwm held low around an early reset
  ext_pulse_a: assert property (ext_clear_o |=> !ext_clear_o)
    else $error("clear pulse longer than one cycle");
  ext_count_a: assert property (ext_clear_o |-> count_o <= 8'h01)
    else $error("count not cleared by reset edge");
  pwm_off_a: assert property (ext_clear_o |-> !pwm_o)
    else $error("pwm high at early reset");
  period_clr_a: assert property (period_match_o |-> count_o == 8'h00)
    else $error("count not cleared at period");

  // Main scenarios reached
  ext_c: cover property (ext_clear_o);
  per_c: cover property (period_match_o);
  pwm_c: cover property ($rose(pwm_o));
endmodule

bind tmrl_timer tmrl_timer_checker #(
  .TIMER_INDEX(TIMER_INDEX),
  .DATA_W(DATA_W)
) u_chk (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .count_o(count_o),
  .period_match_o(period_match_o),
  .ext_clear_o(ext_clear_o),
  .pwm_o(pwm_o)
);

/* tb/testbench.sv */
// Self-checking bench for the timer external reset limit block
`timescale 1ns/1ns
`include "tmrl_defines.svh"
module testbench;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [7:0] count_o;
  logic period_match_o;
  logic ext_clear_o;
  logic pwm_o;
  logic [4:0] sel = 5'h00;
  logic level = 1'b0;
  logic [24:0] src;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] per_q[$];
  logic [7:0] pwm_q[$];
  logic [7:0] since_per = 8'h00;
  logic [7:0] since_clr = 8'hFF;
  logic seen_per = 1'b0;
  logic pwm_d = 1'b0;
  logic [7:0] r;
  logic [4:0] md;
  logic hit;
  int fail_count = 0;
  int n_compared = 0;

  tmrl_src_model u_src (
    .sys_clk_i(sys_clk_i),
    .sel_i(sel),
    .level_i(level),
    .src_o(src)
  );

  tmrl_timer #(.TIMER_INDEX(1), .DATA_W(8)) u_dut (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .timer_input_pin_route_i(src[0]),
    .timer_postscaled_i(src[3:1]),
    .capture_compare_output_i(src[7:4]),
    .pwm_generator_output_i(src[11:8]),
    .comparator_output_i(src[15:14]),
    .zero_cross_output_i(src[16]),
    .logic_cell_output_i(src[20:17]),
    .uart_edge_i(src[24:21]),
    .count_o(count_o),
    .period_match_o(period_match_o),
    .ext_clear_o(ext_clear_o),
    .pwm_o(pwm_o)
  );

  // 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t exp %h got %h", $time, exp, got);
    end
  endtask

  // Spacing of period match pulses, in clock edges
  task automatic cmp_per(input logic [7:0] exp, input logic [7:0] got);
    cmp(exp, got);
  endtask

  // Edges from an external clear to the PWM rising again
  task automatic cmp_pwm(input logic [7:0] exp, input logic [7:0] got);
    cmp(exp, got);
  endtask

  // One bus cycle; strobes stand until the next access or an idle
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (!w) exp_q.push_back(d);
    @(posedge sys_clk_i);
  endtask

  // Drop both strobes, then let n edges pass
  task automatic idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Preset count with the edge, read it back three edges later
  task automatic probe(input logic [7:0] ctl, input logic lv,
                       input logic [7:0] exp);
    bus(1'b1, 3'h2, ctl);
    level <= ~lv;
    idle(6);
    level <= lv;
    bus(1'b1, 3'h1, 8'h80);
    idle(2);
    bus(1'b0, 3'h1, exp);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_q) cmp(exp_q.pop_front(), reg_rdata_o);
    rd_q <= reg_rd_i;
  end

  // Pulse watch: period match spacing, PWM restart after a clear
  always @(posedge sys_clk_i) begin
    if (period_match_o === 1'b1) begin
      if (seen_per && per_q.size() > 0) begin
        cmp_per(per_q.pop_front(), since_per + 8'h01);
      end
      seen_per <= 1'b1;
      since_per <= 8'h00;
    end else if (since_per != 8'hFF) begin
      since_per <= since_per + 8'h01;
    end
    if (ext_clear_o === 1'b1) begin
      since_clr <= 8'h00;
    end else if (since_clr != 8'hFF) begin
      since_clr <= since_clr + 8'h01;
    end
    if (pwm_o === 1'b1 && pwm_d === 1'b0 && pwm_q.size() > 0) begin
      cmp_pwm(pwm_q.pop_front(), since_clr + 8'h01);
    end
    pwm_d <= pwm_o;
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    r = 8'($urandom(32'hded9ef3d));
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    bus(1'b0, 3'h0, 8'hFF);
    bus(1'b0, 3'h2, 8'h00);
    bus(1'b0, 3'h3, 8'h00);
    bus(1'b0, 3'h4, 8'h00);
    bus(1'b1, 3'h3, r);
    bus(1'b0, 3'h3, r & 8'h1F);
    bus(1'b1, 3'h6, r);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b0, 3'h7, 8'h00);
    bus(1'b1, 3'h4, 8'hFF);
    bus(1'b1, 3'h3, 8'h00);
    // Each limit mode and the free mode against both edge directions
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        md = (m == 3) ? 5'h00 : 5'(3 + m);
        hit = md == 5'h03 || (md == 5'h04 && d == 1) ||
              (md == 5'h05 && d == 0);
        probe({3'h4, md}, d[0], hit ? 8'h00 : 8'h82);
      end
    end
    pwm_q.push_back({6'h00, `TMRL_PWM_RESTART_CYC});
    probe(8'hA4, 1'b1, 8'h01);
    // Every selector code, reserved and own-timer codes stay silent
    for (int c = 0; c < 32; c++) begin
      sel <= c[4:0];
      bus(1'b1, 3'h3, {3'h0, c[4:0]});
      hit = c < 25 && c != 1 && c != 12 && c != 13;
      probe(8'h84, 1'b1, hit ? 8'h00 : 8'h82);
    end
    // Short random period to run the period match path
    bus(1'b1, 3'h0, {5'h01, r[2:0]});
    bus(1'b1, 3'h1, 8'h00);
    bus(1'b1, 3'h2, 8'h80);
    repeat (2) per_q.push_back({5'h01, r[2:0]} + 8'h01);
    idle(60);
    bus(1'b0, 3'h5, 8'h06);
    idle(2);
    cmp(8'h00, 8'(per_q.size() + pwm_q.size()));
    test_done();
  end
endmodule
